// ### core/bpa_pkg.sv
// Purpose: Shared constants for the bidirectional pulse accumulator channel
// Assumes: 25 MHz time base, 16-bit register data path
// Notes: Offsets are byte addresses on the plain register port
package bpa_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int MAG_W = 15;

  // Register offsets
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_RESULT = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] ADDR_INFO = 8'h14;

  // Input configuration byte fields
  localparam int ICFG_INT_FAULT = 0;
  localparam int ICFG_INT_SAMPLE = 1;
  localparam int ICFG_MULT_LO = 2;

  // Marker configuration byte fields
  localparam int MCFG_ENABLE = 0;
  localparam int MCFG_PRESET = 1;
  localparam int MCFG_FLAG = 2;
  localparam int MCFG_IRQ = 3;

  // Channel status buffer bits
  localparam int STAT_MARK = 0;
  localparam int STAT_BAD_CMD = 1;
  localparam int STAT_OVERRUN = 2;
  localparam int STAT_W = 3;

  // Interrupt status and mask bits
  localparam int IRQ_SAMPLE = 0;
  localparam int IRQ_MARK = 1;
  localparam int IRQ_FAULT = 2;
  localparam int IRQ_W = 3;

  // Commands while running
  localparam logic [7:0] CMD_COUNT_REQUEST = 8'h01;
  localparam logic [7:0] CMD_NEW_MODE = 8'h80;

  // Count multiplier encodings
  localparam logic [1:0] MULT_X1 = 2'h0;
  localparam logic [1:0] MULT_X2 = 2'h1;

  // Reset values, unit step and saturation limit
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [MAG_W-1:0] MAG_ZERO = 15'h0000;
  localparam logic [MAG_W-1:0] MAG_ONE = 15'h0001;
  localparam logic [MAG_W-1:0] MAG_MAX = 15'h7fff;

  // Timing
  localparam int CLK_MHZ = 25;
  localparam int SAMPLE_INTERVAL_US = 1000;
  localparam int SAMPLE_CYCLES = SAMPLE_INTERVAL_US * CLK_MHZ;

  typedef enum logic [1:0] {
    ST_CFG_INPUT = 2'b00,
    ST_CFG_MARKER = 2'b01,
    ST_RUN = 2'b10
  } bpa_state_type;
endpackage

// ### core/bpa_quad_decoder.sv
// Purpose: Two-phase transition decoder giving up and down step pulses
// Assumes: Phase inputs synchronous to ref_clk_in
// Notes: Illegal double-phase changes give no step
module bpa_quad_decoder (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic phase_a_in,
  input wire logic phase_b_in,
  input wire logic [1:0] mult_in,
  output logic step_up_out,
  output logic step_down_out
);
  logic [1:0] cur;
  logic [1:0] prev;
  wire fwd;
  wire rev;
  wire a_change;
  wire a_rise;
  wire allow;

  function automatic logic is_fwd(input logic [1:0] p, input logic [1:0] c);
    is_fwd = (p == 2'b00 && c == 2'b01) || (p == 2'b01 && c == 2'b11) ||
             (p == 2'b11 && c == 2'b10) || (p == 2'b10 && c == 2'b00);
  endfunction

  assign fwd = is_fwd(prev, cur);
  assign rev = is_fwd(cur, prev);
  assign a_change = prev[1] ^ cur[1];
  assign a_rise = !prev[1] && cur[1];
  assign allow = (mult_in == bpa_pkg::MULT_X1) ? a_rise :
                 (mult_in == bpa_pkg::MULT_X2) ? a_change : 1'b1;

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cur <= 2'b00;
      prev <= 2'b00;
      step_up_out <= 1'b0;
      step_down_out <= 1'b0;
    end else begin
      cur <= {phase_a_in, phase_b_in};
      prev <= cur;
      step_up_out <= fwd && allow;
      step_down_out <= rev && allow;
    end
  end
endmodule // bpa_quad_decoder

// ### core/bpa_accumulator.sv
// Purpose: One channel of bidirectional pulse accumulation with marker handling
// Assumes: Bus master follows the command buffer handshake
// Notes: Counts are sign-magnitude, direction in the top bit
//
// Local design decisions: the register addresses and the address-and-strobe port.
module bpa_accumulator #(
  parameter int SAMPLE_CYCLES = bpa_pkg::SAMPLE_CYCLES,
  parameter logic [14:0] PRESET_VALUE = 15'h0100
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  input wire logic phase_a_in,
  input wire logic phase_b_in,
  input wire logic marker_in,
  output logic irq_out
);
  localparam int CNT_W = $clog2(SAMPLE_CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST_TICK = CNT_W'(SAMPLE_CYCLES - 1);

  bpa_pkg::bpa_state_type state;
  logic [7:0] icfg;
  logic [7:0] mcfg;
  logic [7:0] cmd_byte;
  logic cmd_full;
  logic dir;
  logic [14:0] mag;
  logic [15:0] result;
  logic out_full;
  logic [2:0] status_buf;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [CNT_W-1:0] tick_cnt;
  logic req_done;
  logic marker_d;
  logic next_dir;
  logic [14:0] next_mag;
  wire step_up;
  wire step_down;

  wire running = (state == bpa_pkg::ST_RUN);
  wire wr_cmd = wr_in && (addr_in == bpa_pkg::ADDR_CMD);
  wire wr_irq_stat = wr_in && (addr_in == bpa_pkg::ADDR_IRQ_STAT);
  wire wr_irq_mask = wr_in && (addr_in == bpa_pkg::ADDR_IRQ_MASK);
  wire rd_result = rd_in && (addr_in == bpa_pkg::ADDR_RESULT);
  wire rd_status = rd_in && (addr_in == bpa_pkg::ADDR_STATUS);
  wire take = cmd_full;
  wire tick = running && (tick_cnt == LAST_TICK);
  wire marker_edge = marker_in && !marker_d;
  wire marker_hit = running && mcfg[bpa_pkg::MCFG_ENABLE] && marker_edge;
  wire run_cmd = take && running;
  wire cmd_new_mode = run_cmd && (cmd_byte == bpa_pkg::CMD_NEW_MODE);
  wire cmd_req_ok = run_cmd && (cmd_byte == bpa_pkg::CMD_COUNT_REQUEST) && !req_done;
  wire cmd_bad = run_cmd && !cmd_new_mode && !cmd_req_ok;
  wire [15:0] count_word = {dir, mag};
  wire post = tick || cmd_req_ok;
  wire overrun = post && out_full && !rd_result;
  wire [2:0] new_flags = {overrun, cmd_bad, marker_hit && mcfg[bpa_pkg::MCFG_FLAG]};
  wire fault_posted = overrun || cmd_bad;
  wire [2:0] irq_set = {fault_posted && icfg[bpa_pkg::ICFG_INT_FAULT],
                        marker_hit && mcfg[bpa_pkg::MCFG_IRQ],
                        tick && icfg[bpa_pkg::ICFG_INT_SAMPLE]};
  wire [15:0] info_word = {1'b0, running, out_full, cmd_full, mcfg[3:0], icfg};
  wire [15:0] read_mux = (addr_in == bpa_pkg::ADDR_CMD) ? {15'h0000, cmd_full} :
                         (addr_in == bpa_pkg::ADDR_RESULT) ? result :
                         (addr_in == bpa_pkg::ADDR_STATUS) ? {13'h0000, status_buf} :
                         (addr_in == bpa_pkg::ADDR_IRQ_STAT) ? {13'h0000, irq_stat} :
                         (addr_in == bpa_pkg::ADDR_IRQ_MASK) ? {13'h0000, irq_mask} :
                         (addr_in == bpa_pkg::ADDR_INFO) ? info_word : 16'h0000;

  assign irq_out = |(irq_stat & irq_mask);

  bpa_quad_decoder u_decoder (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .phase_a_in(phase_a_in),
    .phase_b_in(phase_b_in),
    .mult_in(icfg[bpa_pkg::ICFG_MULT_LO +: 2]),
    .step_up_out(step_up),
    .step_down_out(step_down)
  );

  // Next count value
  always_comb begin
    next_dir = dir;
    next_mag = mag;
    if (marker_hit) begin
      next_dir = 1'b0;
      next_mag = mcfg[bpa_pkg::MCFG_PRESET] ? PRESET_VALUE : bpa_pkg::MAG_ZERO;
    end else if (running && step_up) begin
      if (!dir) begin
        next_mag = (mag == bpa_pkg::MAG_MAX) ? mag : mag + bpa_pkg::MAG_ONE;
      end else begin
        next_mag = mag - bpa_pkg::MAG_ONE;
        next_dir = (mag != bpa_pkg::MAG_ONE);
      end
    end else if (running && step_down) begin
      if (!dir && mag == bpa_pkg::MAG_ZERO) begin
        next_dir = 1'b1;
        next_mag = bpa_pkg::MAG_ONE;
      end else if (!dir) begin
        next_mag = mag - bpa_pkg::MAG_ONE;
      end else begin
        next_mag = (mag == bpa_pkg::MAG_MAX) ? mag : mag + bpa_pkg::MAG_ONE;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= bpa_pkg::ST_CFG_INPUT;
      icfg <= bpa_pkg::CFG_RESET;
      mcfg <= bpa_pkg::CFG_RESET;
    end else if (take) begin
      case (state)
        bpa_pkg::ST_CFG_INPUT: begin
          icfg <= cmd_byte;
          state <= bpa_pkg::ST_CFG_MARKER;
        end
        bpa_pkg::ST_CFG_MARKER: begin
          mcfg <= cmd_byte;
          state <= bpa_pkg::ST_RUN;
        end
        bpa_pkg::ST_RUN: begin
          if (cmd_new_mode) begin
            state <= bpa_pkg::ST_CFG_INPUT;
          end
        end
        default: begin
          state <= bpa_pkg::ST_CFG_INPUT;
        end
      endcase
    end
  end

  // Command buffer, taken the cycle after it fills
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cmd_full <= 1'b0;
      cmd_byte <= 8'h00;
    end else if (wr_cmd && !cmd_full) begin
      cmd_full <= 1'b1;
      cmd_byte <= wdata_in[7:0];
    end else if (take) begin
      cmd_full <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dir <= 1'b0;
      mag <= bpa_pkg::MAG_ZERO;
    end else if (!running) begin
      dir <= 1'b0;
      mag <= bpa_pkg::MAG_ZERO;
    end else begin
      dir <= next_dir;
      mag <= next_mag;
    end
  end

  // Interval timer and request limit
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tick_cnt <= '0;
      req_done <= 1'b0;
      marker_d <= 1'b0;
    end else begin
      marker_d <= marker_in;
      tick_cnt <= (!running || tick) ? '0 : tick_cnt + CNT_W'(1);
      req_done <= (running && !tick) && (req_done || cmd_req_ok);
    end
  end

  // Result buffer, set wins over read
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      result <= 16'h0000;
      out_full <= 1'b0;
    end else begin
      if (post) begin
        result <= count_word;
      end
      out_full <= post || (out_full && !rd_result);
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status_buf <= 3'h0;
    end else begin
      status_buf <= (rd_status ? 3'h0 : status_buf) | new_flags;
    end
  end

  // Interrupt status, write one clears, set wins
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_stat <= 3'h0;
      irq_mask <= 3'h0;
      rdata_out <= 16'h0000;
    end else begin
      irq_stat <= (irq_stat & ~(wr_irq_stat ? wdata_in[2:0] : 3'h0)) | irq_set;
      if (wr_irq_mask) begin
        irq_mask <= wdata_in[2:0];
      end
      rdata_out <= rd_in ? read_mux : 16'h0000;
    end
  end

  sequence cfg_done_s;
    take && state == bpa_pkg::ST_CFG_MARKER;
  endsequence

  sequence marker_hit_s;
    running && mcfg[bpa_pkg::MCFG_ENABLE] && marker_edge;
  endsequence

  cfg_order_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    take && state == bpa_pkg::ST_CFG_INPUT |=> state == bpa_pkg::ST_CFG_MARKER && icfg == $past(cmd_byte))
    else $error("input config not stored");
  run_start_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    cfg_done_s |=> running && count_word == 16'h0000)
    else $error("count not zero at run start");
  marker_clear_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    marker_hit_s and !mcfg[bpa_pkg::MCFG_PRESET] |=> count_word == 16'h0000)
    else $error("marker did not clear count");
  marker_preset_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    marker_hit_s and mcfg[bpa_pkg::MCFG_PRESET] |=> count_word == {1'b0, PRESET_VALUE})
    else $error("marker did not load preset");
  sample_post_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    tick |=> out_full && result == $past(count_word))
    else $error("count not posted at interval end");
  no_neg_zero_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    !(dir && mag == bpa_pkg::MAG_ZERO))
    else $error("reverse zero reported");
  step_up_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    running && step_up && !marker_edge && !dir && mag != bpa_pkg::MAG_MAX |=> mag == $past(mag) + 15'h0001)
    else $error("forward step did not increment");
  sample_irq_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    tick && icfg[bpa_pkg::ICFG_INT_SAMPLE] && irq_mask[bpa_pkg::IRQ_SAMPLE] && !wr_irq_mask |=> irq_out)
    else $error("interval interrupt missing");
  fault_irq_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    cmd_bad && icfg[bpa_pkg::ICFG_INT_FAULT] |=> irq_stat[bpa_pkg::IRQ_FAULT] && status_buf[bpa_pkg::STAT_BAD_CMD])
    else $error("fault not posted");
  status_or_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    !rd_status |=> (status_buf & $past(status_buf)) == $past(status_buf))
    else $error("unread status lost");
  req_once_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    cmd_req_ok ##1 (!tick)[*2] ##0 cmd_req_ok |-> 1'b0)
    else $error("second count request served in one interval");
  marker_flag_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    marker_hit_s and mcfg[bpa_pkg::MCFG_FLAG] |=> status_buf[bpa_pkg::STAT_MARK])
    else $error("marker flag not set");
  marker_irq_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    marker_hit_s and mcfg[bpa_pkg::MCFG_IRQ] |=> irq_stat[bpa_pkg::IRQ_MARK])
    else $error("marker interrupt not raised");
  request_post_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    cmd_req_ok |=> out_full && result == $past(count_word))
    else $error("requested count not posted");
  step_down_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    running && step_down && !marker_edge && !dir && mag != bpa_pkg::MAG_ZERO |=> mag == $past(mag) - 15'h0001)
    else $error("reverse step did not decrement");
  idle_zero_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    !running |=> count_word == 16'h0000)
    else $error("count not held at zero before run");
endmodule // bpa_accumulator

// ### dv/bpa_tach_model.sv
// Purpose: Behavioural two-phase tach with marker output
// Assumes: Steps are made on the bench clock
// Notes: Four clocks between phase changes
module bpa_tach_model (
  input wire logic ref_clk_in,
  output logic phase_a_out,
  output logic phase_b_out,
  output logic marker_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] pos = 2'h0;
  initial begin
    phase_a_out = 1'b0;
    phase_b_out = 1'b0;
    marker_out = 1'b0;
  end
  task automatic step(input bit fwd, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk_in);
      pos = fwd ? pos + 2'h1 : pos - 2'h1;
      phase_a_out <= pos[1];
      phase_b_out <= pos[1] ^ pos[0];
      repeat (3) @(posedge ref_clk_in);
    end
  endtask
  task automatic jump();
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk_in);
      phase_a_out <= ~phase_a_out;
      phase_b_out <= ~phase_b_out;
      repeat (3) @(posedge ref_clk_in);
    end
  endtask
  task automatic pulse();
    @(posedge ref_clk_in);
    marker_out <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    marker_out <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
  endtask
endmodule // bpa_tach_model

// ### dv/bpa_accumulator_tb_top.sv
// Purpose: Self-checking bench for one accumulator channel
// Assumes: Short sample interval for simulation
// Notes: Count model kept as an integer
module bpa_accumulator_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SAMPLE = 50;
  localparam logic [14:0] PRESET = 15'h0123;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [15:0] rdata_out;
  logic phase_a_in, phase_b_in, marker_in, irq_out;
  logic [7:0] icfg, mcfg;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int cnt, mul, n;

  always #20 ref_clk_in = ~ref_clk_in;

  bpa_accumulator #(.SAMPLE_CYCLES(SAMPLE), .PRESET_VALUE(PRESET)) i_bpa_accumulator (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .phase_a_in(phase_a_in),
    .phase_b_in(phase_b_in), .marker_in(marker_in), .irq_out(irq_out));
  bpa_tach_model i_bpa_tach_model (.ref_clk_in(ref_clk_in), .phase_a_out(phase_a_in),
    .phase_b_out(phase_b_in), .marker_out(marker_in));

  task automatic finish_test();
    if (errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [15:0] exp_word(input int c);
    int m;
    m = c < 0 ? -c : c;
    if (m > 32767) m = 32767;
    return {(c < 0 && m != 0) ? 1'b1 : 1'b0, m[14:0]};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] mask, input logic [15:0] exp, input string what);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1;
    check(rdata_out & mask, exp, what);
  endtask

  task automatic cmd(input logic [7:0] b);
    wr(bpa_pkg::ADDR_CMD, {8'h00, b});
    repeat (3) @(posedge ref_clk_in);
  endtask

  task automatic sync();
    wr(bpa_pkg::ADDR_IRQ_STAT, 16'h0001);
    #1;
    for (int i = 0; i < 4 * SAMPLE && irq_out !== 1'b1; i++) begin
      @(posedge ref_clk_in);
      #1;
    end
    check({15'h0000, irq_out}, 16'h0001, "interval irq"); // interval interrupt
    rd(bpa_pkg::ADDR_RESULT, 16'hffff, exp_word(cnt), "posted count"); // posted word
    wr(bpa_pkg::ADDR_IRQ_STAT, 16'h0001);
    #1;
    check({15'h0000, irq_out}, 16'h0000, "irq cleared"); // interval irq cleared by write one
  endtask

  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    void'($urandom(56839));
    repeat (12) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    wr(bpa_pkg::ADDR_IRQ_MASK, 16'h0001);
    rd(bpa_pkg::ADDR_IRQ_MASK, 16'hffff, 16'h0001, "mask");
    rd(8'h20, 16'hffff, 16'h0000, "unmapped");
    for (int m = 0; m < 3; m++) begin
      mul = 1 << m;
      icfg = {4'h0, (m == 2) ? 2'b10 : 2'(m), 1'b1, (m == 1) ? 1'b0 : 1'b1};
      mcfg = (m == 0) ? 8'h0d : ((m == 1) ? 8'h0f : 8'h00);
      if (m > 0) cmd(bpa_pkg::CMD_NEW_MODE);
      cmd(icfg); // input byte
      cmd(mcfg); // marker byte
      wr(bpa_pkg::ADDR_IRQ_STAT, 16'h0007);
      cnt = 0;
      rd(bpa_pkg::ADDR_INFO, 16'h4fff, {4'h4, mcfg[3:0], icfg}, "config"); // config held
      sync(); // starts at zero
      n = 4 * $urandom_range(1, 6);
      i_bpa_tach_model.step(1'b1, n);
      cnt += n * mul / 4;
      i_bpa_tach_model.jump();
      sync(); // forward count
      i_bpa_tach_model.step(1'b0, n + 8);
      cnt -= (n + 8) * mul / 4;
      sync(); // reverse past zero
      cmd(bpa_pkg::CMD_COUNT_REQUEST);
      rd(bpa_pkg::ADDR_RESULT, 16'hffff, exp_word(cnt), "requested count"); // instant count
      cmd(bpa_pkg::CMD_COUNT_REQUEST);
      i_bpa_tach_model.pulse();
      if (m == 0) cnt = 0;
      if (m == 1) cnt = int'(PRESET);
      rd(bpa_pkg::ADDR_STATUS, 16'h0003, {14'h0000, 1'b1, mcfg[2]}, "status"); // merged flags
      rd(bpa_pkg::ADDR_IRQ_STAT, 16'h0006, {13'h0000, icfg[0], mcfg[3], 1'b0}, "irq status");
      sync(); // marker effect
    end
    finish_test();
  end
endmodule // bpa_accumulator_tb_top
